// file: rtl/ebm_pkg.sv
// Contract
// - product-term use gives 16 macrocells, each two product terms and one register
// - macrocell output is the registered or bypassed OR of its two terms
// - the block takes 32 inputs from neighbouring local routing
// - nine macrocell outputs loop back as block inputs
// - clock, enable and clear come from dedicated, global or local lines
// - input clock registers write data, strobes and both addresses
// - output clock drives only the read data registers
// - input and output sides have their own enable and clear; in single-port mode the read side uses the input enable and clear
// - device reset clears every register but the memory array and cfg_q, which loads CFG_RESET; a local or global clear empties only its own side's registers
// - single-port mode shares one port; a read clashing with a write is dropped and flagged
package ebm_pkg;
  localparam int MEM_WIDTH    = 8;
  localparam int MEM_DEPTH    = 32;
  localparam int ADDR_W       = 5;
  localparam int NUM_CELLS    = 16;
  localparam int NUM_TERMS    = 32;
  localparam int NUM_LOCAL_IN = 32;
  localparam int NUM_FEEDBACK = 9;
  localparam int LIT_W        = 41;
  localparam int PADDR_W      = 12;

  localparam logic [11:0] OFF_CFG     = 12'h000;
  localparam logic [11:0] OFF_STATUS  = 12'h004;
  localparam logic [11:0] OFF_PT_SEL  = 12'h008;
  localparam logic [11:0] OFF_PT_TRUE = 12'h00c;
  localparam logic [11:0] OFF_PT_COMP = 12'h010;
  localparam logic [11:0] OFF_PT_HI   = 12'h014;

  localparam int CFG_MODE_LSB   = 0;
  localparam int CFG_INCLK_LSB  = 4;
  localparam int CFG_OUTCLK_LSB = 8;
  localparam int CFG_INCLR_LSB  = 12;
  localparam int CFG_OUTCLR_LSB = 16;
  localparam int CFG_INEN_LSB   = 20;
  localparam int CFG_OUTEN_LSB  = 24;
  localparam logic [31:0] CFG_RESET = 32'hffff_fff0;

  localparam int STAT_COLL_BIT  = 16;
  localparam int STAT_MODE_LSB  = 20;
  localparam int STAT_RDATA_LSB = 24;
  localparam int PTHI_COMP_LSB  = 16;
  localparam int PTHI_BYP_BIT   = 31;

  typedef enum logic [1:0] {MODE_IO_CLOCK, MODE_SINGLE_PORT, MODE_PRODUCT_TERM, MODE_SPARE} mode_t;
  typedef enum logic [1:0] {SRC_DEDICATED, SRC_GLOBAL, SRC_LOCAL, SRC_OFF} srcKind_t;
endpackage : ebm_pkg

// file: rtl/mem_port_if.sv
`timescale 1ns/1ns
interface mem_port_if;
  import ebm_pkg::*;
  logic                  wrEn;
  logic [ADDR_W-1:0]     wrAddr;
  logic [ADDR_W-1:0]     rdAddr;
  logic [MEM_WIDTH-1:0]  wrData;
  logic [MEM_WIDTH-1:0]  rdData;
  modport ctrl  (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport store (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : mem_port_if

// file: rtl/memory_array.sv
`timescale 1ns/1ns
module memory_array
  import ebm_pkg::*;
(
  input wire logic  clk,
  mem_port_if.store port
);
  logic [MEM_WIDTH-1:0] cells_q [MEM_DEPTH];

  // storage cells are not control state, so no clear reaches them
  always_ff @(posedge clk) begin
    if (port.wrEn) begin
      cells_q[port.wrAddr] <= port.wrData;
    end
  end

  assign port.rdData = cells_q[port.rdAddr];
endmodule : memory_array

// file: rtl/embedded_memory_block.sv
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
module embedded_memory_block
  import ebm_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic [PADDR_W-1:0]    paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [1:0]            dedClk,
  input  wire logic [3:0]            globalSig,
  input  wire logic [3:0]            ctrlLocal,
  input  wire logic [NUM_LOCAL_IN-1:0] localIn,
  input  wire logic [MEM_WIDTH-1:0]  wrData,
  input  wire logic [ADDR_W-1:0]     wrAddr,
  input  wire logic [ADDR_W-1:0]     rdAddr,
  input  wire logic                  wrStrobe,
  input  wire logic                  readStrobe,
  output logic      [MEM_WIDTH-1:0]  rdData,
  output logic      [NUM_CELLS-1:0]  mcOut
);
  logic [5:0]            pinMeta_q;
  logic [5:0]            pinSync_q;
  logic [31:0]           cfg_q;
  logic [4:0]            ptSel_q;
  logic                  pready_q;
  logic                  pslverr_q;
  logic [31:0]           prdata_q;
  logic [LIT_W-1:0]      trueMask_q [NUM_TERMS];
  logic [LIT_W-1:0]      compMask_q [NUM_TERMS];
  logic [NUM_CELLS-1:0]  bypass_q;
  logic [NUM_CELLS-1:0]  mcReg_q;
  logic [NUM_CELLS-1:0]  mcOut_q;
  logic [MEM_WIDTH-1:0]  wrDataQ_q;
  logic [ADDR_W-1:0]     wrAddrQ_q;
  logic [ADDR_W-1:0]     rdAddrQ_q;
  logic                  wrStrobeQ_q;
  logic                  readStrobeQ_q;
  logic [MEM_WIDTH-1:0]  rdData_q;
  logic                  coll_q;
  logic                  inClkPrev_q;
  logic                  outClkPrev_q;

  mode_t                 mode;
  logic                  memMode;
  logic                  single;
  logic                  ptMode;
  logic                  inClkLvl;
  logic                  outClkLvl;
  logic                  inEvt;
  logic                  outEvt;
  logic                  inEn;
  logic                  outEn;
  logic                  inClr;
  logic                  outClr;
  logic                  inTake;
  logic                  collide;
  logic [LIT_W-1:0]      lits;
  logic [NUM_TERMS-1:0]  terms;
  logic [NUM_CELLS-1:0]  sums;
  logic [NUM_CELLS-1:0]  cellOut;
  logic                  setup;
  logic                  done;
  logic                  wrHit;
  logic [31:0]           readMux;

  mem_port_if memIf ();

  memory_array u_mem (
    .clk  (clk),
    .port (memIf.store)
  );

  function automatic logic pickCtrl(input logic [3:0] src, input logic [5:0] pins,
                                    input logic [3:0] loc, input logic offVal);
    logic [1:0] idx;
    idx = src[1:0];
    unique case (srcKind_t'(src[3:2]))
      SRC_DEDICATED: pickCtrl = pins[idx[0]];
      SRC_GLOBAL:    pickCtrl = pins[3'(idx) + 3'd2];
      SRC_LOCAL:     pickCtrl = loc[idx];
      SRC_OFF:       pickCtrl = offVal;
    endcase
  endfunction : pickCtrl

  function automatic logic regHit(input logic [PADDR_W-1:0] a);
    regHit = (a == OFF_CFG) || (a == OFF_STATUS) || (a == OFF_PT_SEL) ||
             (a == OFF_PT_TRUE) || (a == OFF_PT_COMP) || (a == OFF_PT_HI);
  endfunction : regHit

  function automatic logic termOut(input logic [LIT_W-1:0] l, input logic [LIT_W-1:0] t,
                                   input logic [LIT_W-1:0] c);
    // an empty term yields 0 so an unprogrammed cell stays low
    termOut = (|(t | c)) & (&(l | ~t)) & (&(~l | ~c));
  endfunction : termOut

  // pins and global lines come from outside this clock domain
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pinMeta_q <= 6'h00;
      pinSync_q <= 6'h00;
    end else begin
      pinMeta_q <= {globalSig, dedClk};
      pinSync_q <= pinMeta_q;
    end
  end

  assign mode    = mode_t'(cfg_q[CFG_MODE_LSB +: 2]);
  assign ptMode  = (mode == MODE_PRODUCT_TERM);
  assign single  = (mode == MODE_SINGLE_PORT);
  assign memMode = !ptMode;

  // each side chooses its own clock, enable and clear source
  assign inClkLvl  = pickCtrl(cfg_q[CFG_INCLK_LSB +: 4], pinSync_q, ctrlLocal, 1'b0);
  assign outClkLvl = pickCtrl(cfg_q[CFG_OUTCLK_LSB +: 4], pinSync_q, ctrlLocal, 1'b0);
  assign inEn      = pickCtrl(cfg_q[CFG_INEN_LSB +: 4], pinSync_q, ctrlLocal, 1'b1);
  assign inClr     = pickCtrl(cfg_q[CFG_INCLR_LSB +: 4], pinSync_q, ctrlLocal, 1'b0);
  assign inEvt     = inClkLvl & ~inClkPrev_q;
  // single-port runs the read side from the input clock and controls
  assign outEvt    = single ? inEvt : (outClkLvl & ~outClkPrev_q);
  assign outEn     = single ? inEn :
                     pickCtrl(cfg_q[CFG_OUTEN_LSB +: 4], pinSync_q, ctrlLocal, 1'b1);
  assign outClr    = single ? inClr :
                     pickCtrl(cfg_q[CFG_OUTCLR_LSB +: 4], pinSync_q, ctrlLocal, 1'b0);
  assign inTake    = inEvt & inEn & memMode;
  assign collide   = inTake & single & wrStrobe & readStrobe;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      inClkPrev_q  <= 1'b0;
      outClkPrev_q <= 1'b0;
    end else begin
      inClkPrev_q  <= inClkLvl;
      outClkPrev_q <= outClkLvl;
    end
  end

  // input-side registers
  always_ff @(posedge clk) begin
    if (!rst_b || inClr) begin
      wrDataQ_q     <= '0;
      wrAddrQ_q     <= '0;
      rdAddrQ_q     <= '0;
      wrStrobeQ_q   <= 1'b0;
      readStrobeQ_q <= 1'b0;
    end else if (inTake) begin
      wrDataQ_q     <= wrData;
      wrAddrQ_q     <= wrAddr;
      rdAddrQ_q     <= rdAddr;
      wrStrobeQ_q   <= wrStrobe;
      // a clashing read in single-port mode is dropped, the write goes ahead
      readStrobeQ_q <= readStrobe & ~collide;
    end
  end

  assign memIf.wrEn   = inTake & wrStrobe;
  assign memIf.wrAddr = wrAddr;
  assign memIf.wrData = wrData;
  assign memIf.rdAddr = single ? wrAddrQ_q : rdAddrQ_q;

  // output-side register: moved by the output clock, or by the input clock in single-port mode
  always_ff @(posedge clk) begin
    if (!rst_b || outClr) begin
      rdData_q <= '0;
    end else if (outEvt && outEn && readStrobeQ_q && memMode) begin
      rdData_q <= memIf.rdData;
    end
  end

  // set wins, so a clash in the clearing cycle is never lost
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      coll_q <= 1'b0;
    end else if (collide) begin
      coll_q <= 1'b1;
    end else if (done && pwrite && paddr == OFF_STATUS && pwdata[STAT_COLL_BIT]) begin
      coll_q <= 1'b0;
    end
  end

  // product-term array: 32 local inputs plus nine fed-back cells
  assign lits = {mcOut_q[NUM_FEEDBACK-1:0], localIn};

  always_comb begin
    for (int t = 0; t < NUM_TERMS; t++) begin
      terms[t] = termOut(lits, trueMask_q[t], compMask_q[t]);
    end
    for (int c = 0; c < NUM_CELLS; c++) begin
      sums[c]    = terms[2*c] | terms[2*c+1];
      cellOut[c] = bypass_q[c] ? sums[c] : mcReg_q[c];
    end
  end

  // registered cells load on the input edge only, sharing the memory's input timing
  always_ff @(posedge clk) begin
    if (!rst_b || inClr) begin
      mcReg_q <= '0;
    end else if (inEvt && inEn && ptMode) begin
      mcReg_q <= sums;
    end
  end

  // feedback is taken after this register so bypassed cells cannot loop
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mcOut_q <= '0;
    end else begin
      mcOut_q <= ptMode ? cellOut : '0;
    end
  end

  // APB slave: one wait state, then pready for one cycle
  assign setup = psel & penable & ~pready_q;
  assign done  = psel & penable & pready_q;
  assign wrHit = done & pwrite & regHit(paddr);

  always_comb begin
    readMux = 32'h0000_0000;
    unique case (paddr)
      OFF_CFG:     readMux = cfg_q;
      OFF_STATUS:  readMux = {rdData_q, 2'b00, mode, 3'b000, coll_q, mcOut_q};
      OFF_PT_SEL:  readMux = {27'h0, ptSel_q};
      OFF_PT_TRUE: readMux = trueMask_q[ptSel_q][31:0];
      OFF_PT_COMP: readMux = compMask_q[ptSel_q][31:0];
      OFF_PT_HI:   readMux = {bypass_q[ptSel_q[4:1]], 6'h00, compMask_q[ptSel_q][LIT_W-1:32],
                              7'h00, trueMask_q[ptSel_q][LIT_W-1:32]};
      default:     readMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~regHit(paddr);
      prdata_q  <= (setup && !pwrite) ? readMux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_q   <= CFG_RESET;
      ptSel_q <= 5'h00;
    end else if (wrHit) begin
      if (paddr == OFF_CFG) begin
        cfg_q <= pwdata;
      end
      if (paddr == OFF_PT_SEL) begin
        ptSel_q <= pwdata[4:0];
      end
    end
  end

  // mask storage is configuration, loaded only over the bus
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int t = 0; t < NUM_TERMS; t++) begin
        trueMask_q[t] <= '0;
        compMask_q[t] <= '0;
      end
      bypass_q <= '0;
    end else if (wrHit) begin
      unique case (paddr)
        OFF_PT_TRUE: trueMask_q[ptSel_q][31:0] <= pwdata;
        OFF_PT_COMP: compMask_q[ptSel_q][31:0] <= pwdata;
        OFF_PT_HI: begin
          trueMask_q[ptSel_q][LIT_W-1:32] <= pwdata[NUM_FEEDBACK-1:0];
          compMask_q[ptSel_q][LIT_W-1:32] <= pwdata[PTHI_COMP_LSB +: NUM_FEEDBACK];
          bypass_q[ptSel_q[4:1]]          <= pwdata[PTHI_BYP_BIT];
        end
        default: ;
      endcase
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign rdData  = rdData_q;
  assign mcOut   = mcOut_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_pt_cells_idle: assert property (!ptMode |=> mcOut_q == '0)
    else $error("macrocell output active outside product-term mode");
  a_bypass_path: assert property (ptMode && bypass_q[0] |=> mcOut_q[0] == $past(sums[0]))
    else $error("bypassed cell does not follow its term sum");
  a_input_capture: assert property (inTake && !inClr |=> wrAddrQ_q == $past(wrAddr)
                                    && wrDataQ_q == $past(wrData))
    else $error("input register missed the input clock edge");
  a_out_hold: assert property (!outEvt && !outClr |=> $stable(rdData_q))
    else $error("read data moved without an output clock edge");
  a_in_gate: assert property (inEvt && !inEn && !inClr |=> $stable(wrAddrQ_q))
    else $error("input register moved while its enable was low");
  a_out_clear: assert property (outClr |=> rdData_q == '0)
    else $error("output clear did not empty read data");
  a_single_clash: assert property (collide |=> coll_q && !readStrobeQ_q)
    else $error("single-port clash not flagged");
  a_read_capture: assert property (outEvt && outEn && readStrobeQ_q && memMode && !outClr
                                   |=> rdData_q == $past(memIf.rdData))
    else $error("read data not captured on output edge");
  a_apb_wait: assert property (setup |=> pready_q ##1 !pready_q)
    else $error("apb answer not one wait state");

  // bus answers and register loads
  a_apb_refuse: assert property (done && !regHit(paddr) |-> pslverr_q && prdata_q == '0)
    else $error("unmapped access not refused");
  a_apb_quiet: assert property (!pready_q |-> prdata_q == '0 && !pslverr_q)
    else $error("apb answer outside its cycle");
  a_cfg_load: assert property (wrHit && paddr == OFF_CFG
                               |=> cfg_q == $past(pwdata))
    else $error("configuration write lost");
  a_mask_load: assert property (wrHit && paddr == OFF_PT_TRUE
                                |=> trueMask_q[ptSel_q][31:0] == $past(pwdata))
    else $error("term mask write lost");

  // mode separation and clash handling
  a_cell_hold: assert property (!(inEvt && inEn && ptMode) && !inClr |=> $stable(mcReg_q))
    else $error("macrocell register moved without an input edge");
  a_pt_no_write: assert property (ptMode |-> !memIf.wrEn)
    else $error("memory written in product-term mode");
  a_pt_rd_hold: assert property (ptMode && !outClr |=> $stable(rdData_q))
    else $error("read data moved in product-term mode");
  a_clash_write: assert property (collide |-> memIf.wrEn)
    else $error("clashing write was not carried out");
  a_flag_clear: assert property (done && pwrite && paddr == OFF_STATUS
                                 && pwdata[STAT_COLL_BIT] && !collide |=> !coll_q)
    else $error("clash flag not cleared by software");

  c_write_hit: cover property (wrHit && paddr == OFF_CFG);
  c_clash: cover property (collide);
  c_read_path: cover property (inTake && readStrobe ##[1:20] outEvt && outEn);
  c_pt_out: cover property (ptMode && mcOut_q != '0);
  c_single_read: cover property (single && outEvt && outEn && readStrobeQ_q);
endmodule : embedded_memory_block

// file: tb/fabric_user.sv
`timescale 1ns/1ns
module fabric_user
  import ebm_pkg::*;
(
  input  wire logic                 clk,
  output logic      [3:0]           ctrlLocal,
  output logic      [MEM_WIDTH-1:0] wrData,
  output logic      [ADDR_W-1:0]    wrAddr,
  output logic      [ADDR_W-1:0]    rdAddr,
  output logic                      wrStrobe,
  output logic                      readStrobe
);
  initial begin
    ctrlLocal  = 4'h0;
    wrData     = '0;
    wrAddr     = '0;
    rdAddr     = '0;
    wrStrobe   = 1'b0;
    readStrobe = 1'b0;
  end
  // one rising edge on a local control line, with strobes and data held across it
  task automatic pulse(input int ln, input logic ws, input logic rs, input logic [ADDR_W-1:0] wa,
                       input logic [ADDR_W-1:0] ra, input logic [MEM_WIDTH-1:0] d);
    @(posedge clk);
    ctrlLocal[ln] <= 1'b1;
    wrStrobe      <= ws;
    readStrobe    <= rs;
    wrAddr        <= wa;
    rdAddr        <= ra;
    wrData        <= d;
    @(posedge clk);
    ctrlLocal  <= 4'h0;
    wrStrobe   <= 1'b0;
    readStrobe <= 1'b0;
    // released lines move away so a stale value never passes for a valid one
    wrData     <= ~d;
    wrAddr     <= ~wa;
    rdAddr     <= ~ra;
  endtask : pulse
endmodule : fabric_user

// file: tb/tb.sv
`timescale 1ns/1ns
module tb;
  import ebm_pkg::*;
  logic                  clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [PADDR_W-1:0]    paddr;
  logic [31:0]           pwdata, prdata, rv, seed, lv;
  logic                  err, e;
  logic [3:0]            ctrlLocal;
  logic [31:0]           localIn;
  logic [MEM_WIDTH-1:0]  wrData, rdData;
  logic [ADDR_W-1:0]     wrAddr, rdAddr, a;
  logic                  wrStrobe, readStrobe;
  logic [NUM_CELLS-1:0]  mcOut, mq;
  int                    error_cnt, checks;
  int                    mem [MEM_DEPTH];
  logic [ADDR_W-1:0]     wq [$];

  embedded_memory_block u_embedded_memory_block (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dedClk(2'b00), .globalSig(4'h0), .ctrlLocal(ctrlLocal), .localIn(localIn),
    .wrData(wrData), .wrAddr(wrAddr), .rdAddr(rdAddr), .wrStrobe(wrStrobe), .readStrobe(readStrobe),
    .rdData(rdData), .mcOut(mcOut));
  fabric_user u_fabric_user (.clk(clk), .ctrlLocal(ctrlLocal), .wrData(wrData), .wrAddr(wrAddr),
    .rdAddr(rdAddr), .wrStrobe(wrStrobe), .readStrobe(readStrobe));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) localIn <= xs();

  task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp32
  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp8

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no local limit: a slave that never answers is caught by the watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  initial begin
    #2000000;
    error_cnt++;
    conclude();
  end

  initial begin
    seed = 32'hb860;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, OFF_CFG, 32'h0);
    cmp32("cfg reset", CFG_RESET, rv);
    apb(1'b0, 12'h100, 32'h0);
    cmp32("unmapped err", 32'h1, {31'h0, err});
    $display("test reset done");
    // input clock local 0, output clock local 1, output clear local 2
    apb(1'b1, OFF_CFG, 32'hfffa_f980);
    apb(1'b0, OFF_CFG, 32'h0);
    cmp32("cfg", 32'hfffa_f980, rv);
    for (int i = 0; i < 8; i++) begin
      a = 5'(xs() % MEM_DEPTH);
      mem[a] = xs() & 32'hff;
      wq.push_back(a);
      u_fabric_user.pulse(0, 1'b1, 1'b0, a, ~a, mem[a][7:0]);
    end
    // input enable moved to a dedicated pin tied low, so this write must not land
    apb(1'b1, OFF_CFG, 32'hff0a_f980);
    u_fabric_user.pulse(0, 1'b1, 1'b0, wq[0], 5'h0, ~mem[wq[0]][7:0]);
    apb(1'b1, OFF_CFG, 32'hfffa_f980);
    // only written cells are read back, the array itself has no reset
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? wq[0] : wq[xs() % wq.size()];
      u_fabric_user.pulse(0, 1'b0, 1'b1, a, a, 8'h0);
      u_fabric_user.pulse(1, 1'b0, 1'b0, ~a, ~a, 8'h0);
      repeat (2) @(posedge clk);
      cmp8("rdData", mem[a][7:0], rdData);
      cmp32("mcOut idle", 32'h0, {16'h0, mcOut});
    end
    $display("test io clock done");
    u_fabric_user.pulse(2, 1'b0, 1'b0, 5'h0, 5'h0, 8'h0);
    repeat (2) @(posedge clk);
    cmp8("rdData cleared", 8'h0, rdData);
    $display("test output clear done");
    apb(1'b1, OFF_CFG, 32'hfffa_f981);
    a = 5'h1f;
    mem[a] = 8'ha5;
    u_fabric_user.pulse(0, 1'b1, 1'b1, a, 5'h0, 8'ha5);
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp32("clash set", 32'h0011_0000, rv & 32'h0031_0000);
    apb(1'b1, OFF_STATUS, 32'h0001_0000);
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp32("clash cleared", 32'h0010_0000, rv & 32'h0031_0000);
    u_fabric_user.pulse(0, 1'b0, 1'b1, a, 5'h0, 8'h0);
    // the read is registered on one input edge and captured on the next
    u_fabric_user.pulse(0, 1'b0, 1'b0, a, 5'h0, 8'h0);
    repeat (2) @(posedge clk);
    cmp8("single port read", mem[a][7:0], rdData);
    $display("test single port done");
    // cells 0 and 2 bypassed, cell 1 registered; cell 2 reads cell 0 back
    apb(1'b1, OFF_PT_SEL, 32'h0);
    apb(1'b1, OFF_PT_TRUE, 32'h1);
    apb(1'b1, OFF_PT_COMP, 32'h2);
    apb(1'b1, OFF_PT_HI, 32'h8000_0000);
    apb(1'b1, OFF_PT_SEL, 32'h1);
    apb(1'b1, OFF_PT_TRUE, 32'h4);
    apb(1'b1, OFF_PT_SEL, 32'h2);
    apb(1'b1, OFF_PT_TRUE, 32'h8);
    apb(1'b1, OFF_PT_SEL, 32'h4);
    apb(1'b1, OFF_PT_HI, 32'h8000_0001);
    apb(1'b0, OFF_PT_HI, 32'h0);
    cmp32("pt hi", 32'h8000_0001, rv);
    apb(1'b1, OFF_CFG, 32'hfffa_f982);
    @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      lv = localIn;
      mq = mcOut;
      @(posedge clk);
      cmp8("cell0", {7'h0, (lv[0] & ~lv[1]) | lv[2]}, {7'h0, mcOut[0]});
      cmp8("cell2", {7'h0, mq[0]}, {7'h0, mcOut[2]});
    end
    for (int i = 0; i < 4; i++) begin
      u_fabric_user.pulse(0, 1'b0, 1'b0, 5'h0, 5'h0, 8'h0);
      // pulse returns at the loading edge, before localIn moves on
      e = localIn[3];
      repeat (2) @(posedge clk);
      cmp8("cell1", {7'h0, e}, {7'h0, mcOut[1]});
    end
    $display("test product term done");
    conclude();
  end
endmodule : tb
